// ==== bench/svp_chk.sv ====
// bus and pin timing checker of the serial port
`timescale 1ns/1ps
`default_nettype none
module svp_chk
  import svp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic txd,
  input wire logic rxd_oe,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // answers come one cycle after the handshake and stand until taken
  chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write answer missing");
  chk_b_stand: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  chk_r_stand: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  // no new request while an answer waits, which would lose it
  chk_busy_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h80
    |=> s_axi_rresp == SVP_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read accepted");
  chk_reset_idle: assert property ($rose(aresetn) |-> txd && !rxd_oe && !irq)
    else $error("pins not idle after reset");
  // the data pin is only driven by a buffer write
  chk_drive_cause: assert property ($rose(rxd_oe) |-> s_axi_bvalid && s_axi_bresp == SVP_RESP_OKAY)
    else $error("data pin driven without write");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($rose(rxd_oe));
  cover property ($rose(irq));
endmodule // svp_chk

bind svp_serial_port svp_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .txd(txd), .rxd_oe(rxd_oe), .irq(irq));
`default_nettype wire

// ==== bench/svp_remote.sv ====
// remote serial device sending frames into the receive pin
`timescale 1ns/1ps
`default_nettype none
module svp_remote
(
  // clock
  input wire logic aclk,
  // line toward the receive pin, pulled high when idle
  output logic line
);
  initial line = 1'b1;
  // low start, data lsb first, ninth bit, high stop; a 10-bit frame passes 1 as ninth
  task automatic send(input logic [7:0] d, input logic n9, input int per);
    logic [10:0] f;
    f = {1'b1, n9, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line <= f[i];
      repeat (per) @(posedge aclk);
    end
  endtask
endmodule // svp_remote
`default_nettype wire

// ==== bench/svp_serial_port_tb_top.sv ====
// self-checking bench of the four-mode serial port
`timescale 1ns/1ps
`default_nettype none
module svp_serial_port_tb_top
  import svp_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0, ovf1 = 1'b0;
  logic [1:0] ovf_count = 2'h0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [3:0] ws = 4'h0;
  logic [31:0] wd = 32'h0, rdata, rv;
  logic [1:0] bresp, rresp, rs;
  logic awready, wready, bvalid, arready, rvalid, txd, rxd_out, rxd_oe, irq, line;
  logic [10:0] f;
  int failures = 0, tests_run = 0, lo;
  // register address beside the read response it must give
  logic [9:0] rows [5] = '{{SVP_ADDR_CONTROL, SVP_RESP_OKAY}, {SVP_ADDR_RATE, SVP_RESP_OKAY},
    {SVP_ADDR_IRQ_STATUS, SVP_RESP_OKAY}, {SVP_ADDR_IRQ_MASK, SVP_RESP_OKAY}, {8'h80, SVP_RESP_SLVERR}};
  always #25 aclk = ~aclk;
  // timer 1 overflows every second clock, timer 2 every fourth, so a wrong timer choice shows
  always @(posedge aclk) ovf1 <= ~ovf1;
  always @(posedge aclk) ovf_count <= ovf_count + 2'h1;
  svp_serial_port DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer1_overflow(ovf1), .timer2_overflow(&ovf_count),
    .txd(txd), .rxd_in(rxd_oe ? rxd_out : line), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .irq(irq));
  svp_remote remote (.aclk(aclk), .line(line));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic pa, pw;
    @(posedge aclk);
    awa <= a; wd <= {24'h0, d}; ws <= 4'h1; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && awready === 1'b1) begin pa = 1'b0; awv <= 1'b0; end
      if (pw && wready === 1'b1) begin pw = 1'b0; wv <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    ara <= a; arv <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arv <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rv = rdata; rs = rresp; rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    rd(a);
    chk(n, e, rv);
  endtask
  // samples each bit of an asynchronous frame on the transmit pin at mid-bit
  task automatic cap(input int per);
    while (txd !== 1'b0) @(posedge aclk);
    repeat (per / 2) @(posedge aclk);
    for (int i = 0; i < 11; i++) begin f[i] = txd; repeat (per) @(posedge aclk); end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(rows[i][9:2]);
      chk("reset value", 32'h0, rv); chk("response", {30'h0, rows[i][1:0]}, {30'h0, rs});
    end
    wr(8'h80, 8'h01); chk("write resp", {30'h0, SVP_RESP_SLVERR}, {30'h0, rs});
    // fixed 11-bit mode at clk/16, both directions at once
    wr(SVP_ADDR_RATE, 8'h02); wr(SVP_ADDR_IRQ_MASK, 8'h07); wr(SVP_ADDR_CONTROL, 8'h98);
    @(posedge aclk);
    fork wr(SVP_ADDR_BUFFER, 8'hA5); cap(16); remote.send(8'h3C, 1'b1, 16); join
    repeat (20) @(posedge aclk);
    chk("frame out", {21'h0, 2'b11, 8'hA5, 1'b0}, {21'h0, f});
    chk("irq on", 32'h1, {31'h0, irq});
    rc(SVP_ADDR_IRQ_STATUS, 32'h3, "status");
    rc(SVP_ADDR_IRQ_STATUS, 32'h0, "status cleared");
    chk("irq off", 32'h0, {31'h0, irq});
    rc(SVP_ADDR_CONTROL, 32'h9F, "control");
    rc(SVP_ADDR_BUFFER, 32'h3C, "rx byte");
    // second byte while the first flag still stands
    remote.send(8'h55, 1'b0, 16);
    repeat (20) @(posedge aclk);
    rc(SVP_ADDR_BUFFER, 32'h3C, "old byte kept");
    rc(SVP_ADDR_CONTROL, 32'h9F, "ninth kept");
    rd(SVP_ADDR_IRQ_STATUS); chk("overrun", 32'h1, {31'h0, rv[2]});
    // 10-bit mode on timer 1, first with reception off
    wr(SVP_ADDR_CONTROL, 8'h40); remote.send(8'h12, 1'b1, 32); repeat (40) @(posedge aclk);
    rc(SVP_ADDR_CONTROL, 32'h40, "rx disabled");
    wr(SVP_ADDR_CONTROL, 8'h50); remote.send(8'h81, 1'b1, 32); repeat (40) @(posedge aclk);
    rc(SVP_ADDR_CONTROL, 32'h55, "stop as ninth");
    rc(SVP_ADDR_BUFFER, 32'h81, "rx 10-bit");
    // shift mode at clk/6: data read while the shift clock is low
    wr(SVP_ADDR_RATE, 8'h00); wr(SVP_ADDR_CONTROL, 8'h00);
    fork wr(SVP_ADDR_BUFFER, 8'h96);
      for (int i = 0; i < 8; i++) begin
        while (txd !== 1'b0) @(posedge aclk);
        f[i] = rxd_out;
        lo = 0;
        while (txd !== 1'b1) begin @(posedge aclk); lo++; end
      end
    join
    chk("shift out", 32'h96, {24'h0, f[7:0]});
    chk("shift low", 32'h3, lo);
    repeat (8) @(posedge aclk);
    chk("pin released", 32'h0, {31'h0, rxd_oe});
    rc(SVP_ADDR_CONTROL, 32'h02, "tx flag");
    // shift reception with the line idle high, then the variable 11-bit mode on timer 2
    wr(SVP_ADDR_CONTROL, 8'h10); repeat (70) @(posedge aclk);
    rc(SVP_ADDR_BUFFER, 32'hFF, "shift rx");
    rc(SVP_ADDR_CONTROL, 32'h11, "shift rx flag");
    wr(SVP_ADDR_RATE, 8'h08); wr(SVP_ADDR_CONTROL, 8'hD8); remote.send(8'h6B, 1'b1, 64);
    repeat (80) @(posedge aclk);
    rc(SVP_ADDR_CONTROL, 32'hDD, "variable ninth");
    rc(SVP_ADDR_BUFFER, 32'h6B, "rx timer 2");
    end_of_test;
  end
  // run takes a few thousand cycles; cut a hang well beyond that
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    end_of_test;
  end
endmodule // svp_serial_port_tb_top
`default_nettype wire

// ==== rtl/svp_pkg.sv ====
// shared constants and types of the four-mode serial port
package svp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte addresses on the AXI4-Lite bus
  localparam logic [7:0] SVP_ADDR_CONTROL = 8'h98;
  localparam logic [7:0] SVP_ADDR_BUFFER = 8'h9C;
  localparam logic [7:0] SVP_ADDR_RATE = 8'hA0;
  localparam logic [7:0] SVP_ADDR_IRQ_STATUS = 8'hA4;
  localparam logic [7:0] SVP_ADDR_IRQ_MASK = 8'hA8;

  // values after reset
  localparam logic [7:0] SVP_CONTROL_RESET = 8'h00;
  localparam logic [3:0] SVP_RATE_RESET = 4'h0;
  localparam logic [2:0] SVP_IRQ_RESET = 3'h0;

  // AXI responses
  localparam logic [1:0] SVP_RESP_OKAY = 2'h0;
  localparam logic [1:0] SVP_RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // bit timing: shift-mode divisors of the system clock
  localparam logic [4:0] SVP_DIV_COMPAT_SLOW = 5'h06;
  localparam logic [4:0] SVP_DIV_COMPAT_FAST = 5'h03;
  localparam logic [4:0] SVP_DIV_FAST_SLOW = 5'h04;
  localparam logic [4:0] SVP_DIV_FAST_FAST = 5'h02;
  // fixed 11-bit mode: oversample every clock (1/16) or every second (1/32)
  localparam logic [4:0] SVP_DIV_FIXED_SLOW = 5'h02;
  // sixteen oversample ticks a bit, sampled at the eighth
  localparam logic [3:0] SVP_OS_LAST = 4'hF;
  localparam logic [3:0] SVP_OS_SAMPLE = 4'h7;

  // bits per frame and samples per reception
  localparam logic [3:0] SVP_BITS_SHIFT = 4'h8;
  localparam logic [3:0] SVP_BITS_ASYNC10 = 4'hA;
  localparam logic [3:0] SVP_BITS_ASYNC11 = 4'hB;
  localparam logic [3:0] SVP_RX_SAMPLES = 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  // modes, as the two mode-select bits
  typedef enum logic [1:0] {
    SVP_MODE_SHIFT = 2'b00,
    SVP_MODE_ASYNC10 = 2'b01,
    SVP_MODE_ASYNC11_FIXED = 2'b10,
    SVP_MODE_ASYNC11_VAR = 2'b11
  } svp_mode_type;

  typedef enum logic [1:0] {
    SVP_TX_IDLE = 2'b00,
    SVP_TX_ASYNC = 2'b01,
    SVP_TX_SHIFT = 2'b10
  } svp_tx_state_type;

  typedef enum logic [1:0] {
    SVP_RX_IDLE = 2'b00,
    SVP_RX_START = 2'b01,
    SVP_RX_DATA = 2'b10,
    SVP_RX_SHIFT = 2'b11
  } svp_rx_state_type;

  // serial control register, bit 7 first
  typedef struct packed {
    logic mode_select_high;
    logic mode_select_low;
    logic multiprocessor_enable;
    logic receive_enable;
    logic transmit_ninth_bit;
    logic received_ninth_bit;
    logic transmit_complete_flag;
    logic receive_complete_flag;
  } svp_ctrl_type;

  // rate register, bit 3 first
  typedef struct packed {
    logic async_timer2;
    logic shift_timer;
    logic rate_double;
    logic fast_timing;
  } svp_rate_type;

  // interrupt status and mask layout, bit 2 first
  typedef struct packed {
    logic overrun;
    logic rx_done;
    logic tx_done;
  } svp_event_type;

  typedef struct packed {
    logic [4:0] count;
    logic timer_phase;
  } svp_rate_state_type;

  typedef struct packed {
    svp_ctrl_type ctrl;
    svp_rate_type rate;
    svp_event_type irq_status;
    svp_event_type irq_mask;
    logic [7:0] rx_buffer;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    svp_tx_state_type tx_state;
    logic [10:0] tx_frame;
    logic [3:0] tx_bits;
    logic [3:0] tx_os;
    logic txd;
    logic rxd_out;
    logic rxd_oe;
    svp_rx_state_type rx_state;
    logic [8:0] rx_shift;
    logic [3:0] rx_bits;
    logic [3:0] rx_os;
    logic rx_armed;
    logic sync1;
    logic sync2;
    logic sync3;
    logic rxd_level;
  } svp_state_type;

endpackage

// ==== rtl/svp_rate_gen.sv ====
// bit-rate enables for the serial port: shift clock edges and oversample ticks
`timescale 1ns/1ps
`default_nettype none
module svp_rate_gen
  import svp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // configuration
  input wire svp_mode_type mode,
  input wire svp_rate_type rate,
  // timer overflows and restart from the shifter
  input wire logic timer1_overflow,
  input wire logic timer2_overflow,
  input wire logic shift_restart,
  // one-cycle enables
  output logic oversample_tick,
  output logic shift_fall,
  output logic shift_rise
);

  svp_rate_state_type cur;
  svp_rate_state_type next_cur;
  logic [4:0] divisor;

  ////////////////////////////////////////////////////////////////////////////
  // divider: one counter serves shift mode unless shift_timer picks timer 1, and the fixed 11-bit mode; the other two modes pass timer overflows
  always_comb begin
    next_cur = cur;
    oversample_tick = 1'b0;
    shift_fall = 1'b0;
    shift_rise = 1'b0;
    if (rate.fast_timing) begin
      divisor = rate.rate_double ? SVP_DIV_FAST_FAST : SVP_DIV_FAST_SLOW;
    end else begin
      divisor = rate.rate_double ? SVP_DIV_COMPAT_FAST : SVP_DIV_COMPAT_SLOW;
    end
    unique case (mode)
      SVP_MODE_SHIFT: begin
        if (shift_restart) begin
          next_cur.count = 5'h00;
          next_cur.timer_phase = 1'b0;
        end else if (rate.shift_timer) begin
          // each overflow is half a bit: low half, then high half
          if (timer1_overflow) begin
            shift_fall = ~cur.timer_phase;
            shift_rise = cur.timer_phase;
            next_cur.timer_phase = ~cur.timer_phase;
          end
        end else begin
          // low from count 0, high from half the divisor; odd divisors favour high
          shift_fall = (cur.count == 5'h00);
          shift_rise = (cur.count == (divisor >> 1));
          next_cur.count = (cur.count == divisor - 5'h01) ? 5'h00 : cur.count + 5'h01;
        end
      end
      SVP_MODE_ASYNC10, SVP_MODE_ASYNC11_VAR: begin
        oversample_tick = rate.async_timer2 ? timer2_overflow : timer1_overflow;
      end
      SVP_MODE_ASYNC11_FIXED: begin
        // 1/16 ticks every clock, 1/32 every second clock
        if (rate.rate_double) begin
          oversample_tick = 1'b1;
        end else begin
          oversample_tick = (cur.count == 5'h00);
          next_cur.count = (cur.count == SVP_DIV_FIXED_SLOW - 5'h01) ? 5'h00 : cur.count + 5'h01;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

endmodule // svp_rate_gen
`default_nettype wire

// ==== rtl/svp_serial_port.sv ====
// four-mode serial port with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module svp_serial_port
  import svp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // timer overflow pulses from on-chip timers
  input wire logic timer1_overflow,
  input wire logic timer2_overflow,
  // serial pins
  output logic txd,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  // interrupt
  output logic irq
);

  svp_state_type cur;
  svp_state_type next_cur;
  svp_mode_type mode;
  svp_event_type events;
  logic oversample_tick;
  logic shift_fall;
  logic shift_rise;
  logic shift_restart;
  logic buf_write;
  logic read_clear;
  logic do_write;
  logic [3:0] frame_len;
  logic [8:0] rx_next_shift;
  logic rx_finish;

  ////////////////////////////////////////////////////////////////////////////
  // bit-rate enables
  svp_rate_gen u_rate (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(mode),
    .rate(cur.rate),
    .timer1_overflow(timer1_overflow),
    .timer2_overflow(timer2_overflow),
    .shift_restart(shift_restart),
    .oversample_tick(oversample_tick),
    .shift_fall(shift_fall),
    .shift_rise(shift_rise)
  );

  // bus handshakes and pin outputs straight from state
  assign mode = svp_mode_type'({cur.ctrl.mode_select_high, cur.ctrl.mode_select_low});
  assign s_axi_awready = ~cur.aw_held & ~cur.bvalid;
  assign s_axi_wready = ~cur.w_held & ~cur.bvalid;
  assign s_axi_arready = ~cur.rvalid;
  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_bresp = cur.bresp;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rdata = cur.rdata;
  assign s_axi_rresp = cur.rresp;
  assign txd = cur.txd;
  assign rxd_out = cur.rxd_out;
  assign rxd_oe = cur.rxd_oe;
  assign irq = |(cur.irq_status & cur.irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic: bus first, then the engines, then a fresh transmit load,
  // so that hardware flag sets win over a software clear in the same cycle
  always_comb begin
    next_cur = cur;
    events = '0;
    buf_write = 1'b0;
    read_clear = 1'b0;
    shift_restart = 1'b0;
    rx_finish = 1'b0;
    rx_next_shift = {cur.rxd_level, cur.rx_shift[8:1]};
    frame_len = (mode == SVP_MODE_ASYNC10) ? SVP_BITS_ASYNC10 : SVP_BITS_ASYNC11;

    // pin synchroniser: a new level counts once stages two and three agree
    next_cur.sync1 = rxd_in;
    next_cur.sync2 = cur.sync1;
    next_cur.sync3 = cur.sync2;
    if (cur.sync2 == cur.sync3) begin
      next_cur.rxd_level = cur.sync3;
    end

    // write channels are taken in either order and held until both are in
    if (s_axi_awvalid && s_axi_awready) begin
      next_cur.aw_held = 1'b1;
      next_cur.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_cur.w_held = 1'b1;
      next_cur.w_data = s_axi_wdata[7:0];
      next_cur.w_strb0 = s_axi_wstrb[0];
    end
    if (cur.bvalid && s_axi_bready) begin
      next_cur.bvalid = 1'b0;
    end
    do_write = next_cur.aw_held & next_cur.w_held & ~cur.bvalid;
    if (do_write) begin
      next_cur.aw_held = 1'b0;
      next_cur.w_held = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = SVP_RESP_OKAY;
      // all registers live in byte lane 0; without its strobe nothing changes
      unique case (next_cur.aw_addr)
        SVP_ADDR_CONTROL: if (next_cur.w_strb0) next_cur.ctrl = svp_ctrl_type'(next_cur.w_data);
        SVP_ADDR_BUFFER: buf_write = next_cur.w_strb0;
        SVP_ADDR_RATE: if (next_cur.w_strb0) next_cur.rate = svp_rate_type'(next_cur.w_data[3:0]);
        SVP_ADDR_IRQ_STATUS: ; // cleared by reading only
        SVP_ADDR_IRQ_MASK: if (next_cur.w_strb0) next_cur.irq_mask = svp_event_type'(next_cur.w_data[2:0]);
        default: next_cur.bresp = SVP_RESP_SLVERR;
      endcase
    end

    // read channel: data are captured on the address handshake
    if (cur.rvalid && s_axi_rready) begin
      next_cur.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp = SVP_RESP_OKAY;
      next_cur.rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        SVP_ADDR_CONTROL: next_cur.rdata[7:0] = cur.ctrl;
        SVP_ADDR_BUFFER: next_cur.rdata[7:0] = cur.rx_buffer;
        SVP_ADDR_RATE: next_cur.rdata[3:0] = cur.rate;
        SVP_ADDR_IRQ_STATUS: begin
          next_cur.rdata[2:0] = cur.irq_status;
          read_clear = 1'b1;
        end
        SVP_ADDR_IRQ_MASK: next_cur.rdata[2:0] = cur.irq_mask;
        default: next_cur.rresp = SVP_RESP_SLVERR;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // transmitter, independent of the receiver except in shift mode
    unique case (cur.tx_state)
      SVP_TX_IDLE: ;
      SVP_TX_ASYNC: begin
        if (oversample_tick) begin
          next_cur.tx_os = cur.tx_os + 4'h1;
          if (cur.tx_os == SVP_OS_LAST) begin
            // ones are shifted in behind the loaded stop bit as the frame drains
            next_cur.tx_frame = {1'b1, cur.tx_frame[10:1]};
            next_cur.tx_bits = cur.tx_bits + 4'h1;
            next_cur.txd = cur.tx_frame[1];
            if (cur.tx_bits + 4'h1 == frame_len) begin
              next_cur.tx_state = SVP_TX_IDLE;
              next_cur.txd = 1'b1;
              next_cur.ctrl.transmit_complete_flag = 1'b1;
              events.tx_done = 1'b1;
            end
          end
        end
      end
      SVP_TX_SHIFT: begin
        // transmit pin is the shift clock, data change after its rising edge
        if (shift_fall) begin
          next_cur.txd = 1'b0;
        end
        if (shift_rise) begin
          next_cur.txd = 1'b1;
          next_cur.tx_frame = {1'b1, cur.tx_frame[10:1]};
          next_cur.tx_bits = cur.tx_bits + 4'h1;
          next_cur.rxd_out = cur.tx_frame[1];
          if (cur.tx_bits + 4'h1 == SVP_BITS_SHIFT) begin
            next_cur.tx_state = SVP_TX_IDLE;
            next_cur.rxd_oe = 1'b0;
            next_cur.ctrl.transmit_complete_flag = 1'b1;
            events.tx_done = 1'b1;
          end
        end
      end
      default: next_cur.tx_state = SVP_TX_IDLE;
    endcase

    //////////////////////////////////////////////////////////////////////////
    // receiver; the line must go high before a new start bit is accepted,
    // so a line held low does not retrigger
    if (cur.rxd_level && cur.rx_state == SVP_RX_IDLE) begin
      next_cur.rx_armed = 1'b1;
    end
    unique case (cur.rx_state)
      SVP_RX_IDLE: begin
        if (mode == SVP_MODE_SHIFT) begin
          if (!cur.ctrl.receive_complete_flag && cur.ctrl.receive_enable
              && cur.tx_state == SVP_TX_IDLE && !buf_write) begin
            next_cur.rx_state = SVP_RX_SHIFT;
            next_cur.rx_bits = 4'h0;
            next_cur.rxd_oe = 1'b0;
            next_cur.txd = 1'b1;
            shift_restart = 1'b1;
          end
        end else if (cur.ctrl.receive_enable && cur.rx_armed && !cur.rxd_level) begin
          next_cur.rx_state = SVP_RX_START;
          next_cur.rx_os = 4'h0;
          next_cur.rx_bits = 4'h0;
          next_cur.rx_armed = 1'b0;
        end
      end
      SVP_RX_START: begin
        if (oversample_tick) begin
          next_cur.rx_os = cur.rx_os + 4'h1;
          // a start bit that is high again at mid-bit was a glitch
          if (cur.rx_os == SVP_OS_SAMPLE) begin
            next_cur.rx_state = cur.rxd_level ? SVP_RX_IDLE : SVP_RX_DATA;
          end
        end
      end
      SVP_RX_DATA: begin
        if (oversample_tick) begin
          next_cur.rx_os = cur.rx_os + 4'h1;
          if (cur.rx_os == SVP_OS_SAMPLE) begin
            // eight data bits then stop (10-bit) or ninth bit (11-bit)
            next_cur.rx_shift = rx_next_shift;
            next_cur.rx_bits = cur.rx_bits + 4'h1;
            if (cur.rx_bits + 4'h1 == SVP_RX_SAMPLES) begin
              rx_finish = 1'b1;
            end
          end
        end
      end
      SVP_RX_SHIFT: begin
        if (shift_fall) begin
          next_cur.txd = 1'b0;
        end
        if (shift_rise) begin
          // sample on the rising edge of the shift clock
          next_cur.txd = 1'b1;
          next_cur.rx_shift = rx_next_shift;
          next_cur.rx_bits = cur.rx_bits + 4'h1;
          if (cur.rx_bits + 4'h1 == SVP_BITS_SHIFT) begin
            rx_finish = 1'b1;
          end
        end
      end
    endcase

    // hand the byte over, unless the receive flag of the last one still stands
    if (rx_finish) begin
      next_cur.rx_state = SVP_RX_IDLE;
      if (!next_cur.ctrl.receive_complete_flag) begin
        next_cur.ctrl.receive_complete_flag = 1'b1;
        events.rx_done = 1'b1;
        if (cur.rx_state == SVP_RX_SHIFT) begin
          next_cur.rx_buffer = rx_next_shift[8:1];
        end else begin
          next_cur.rx_buffer = rx_next_shift[7:0];
          // stop bit in 10-bit mode, ninth bit in 11-bit modes
          next_cur.ctrl.received_ninth_bit = rx_next_shift[8];
        end
      end else begin
        events.overrun = 1'b1;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // a buffer write always (re)starts a transmission
    if (buf_write) begin
      next_cur.tx_bits = 4'h0;
      next_cur.tx_os = 4'h0;
      if (mode == SVP_MODE_SHIFT) begin
        // the shared data pin is driven, so a shift reception gives way
        next_cur.tx_state = SVP_TX_SHIFT;
        next_cur.tx_frame = {3'b111, next_cur.w_data};
        next_cur.rxd_out = next_cur.w_data[0];
        next_cur.rxd_oe = 1'b1;
        next_cur.txd = 1'b1;
        next_cur.rx_state = SVP_RX_IDLE;
        shift_restart = 1'b1;
      end else begin
        next_cur.tx_state = SVP_TX_ASYNC;
        if (mode == SVP_MODE_ASYNC10) begin
          next_cur.tx_frame = {2'b11, next_cur.w_data, 1'b0};
        end else begin
          next_cur.tx_frame = {1'b1, cur.ctrl.transmit_ninth_bit, next_cur.w_data, 1'b0};
        end
        next_cur.txd = 1'b0;
      end
    end

    // sticky interrupt bits; an event in the clearing read survives
    next_cur.irq_status = (read_clear ? SVP_IRQ_RESET : cur.irq_status) | events;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; idle line levels are high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= '0;
      cur.ctrl <= svp_ctrl_type'(SVP_CONTROL_RESET);
      cur.rate <= svp_rate_type'(SVP_RATE_RESET);
      cur.irq_status <= svp_event_type'(SVP_IRQ_RESET);
      cur.irq_mask <= svp_event_type'(SVP_IRQ_RESET);
      cur.tx_state <= SVP_TX_IDLE;
      cur.rx_state <= SVP_RX_IDLE;
      cur.txd <= 1'b1;
      cur.rxd_out <= 1'b1;
      cur.sync1 <= 1'b1;
      cur.sync2 <= 1'b1;
      cur.sync3 <= 1'b1;
      cur.rxd_level <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

endmodule // svp_serial_port
`default_nettype wire
